// ==== rtl/ecc_pkg.sv ====
// Package: register map, field positions, reset values and timing of the control bank
package ecc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_SCRATCH = 8'h00;
  localparam logic [7:0] ADDR_UNLOCK = 8'h01;
  localparam logic [7:0] ADDR_WDG_FIRST = 8'h02;
  localparam logic [7:0] ADDR_WDG_SECOND = 8'h03;
  localparam logic [7:0] ADDR_WDG_THIRD = 8'h04;
  localparam logic [7:0] ADDR_HOST_IO = 8'h05;
  localparam logic [7:0] ADDR_LOOP_CTRL = 8'h06;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h07;
  localparam logic [7:0] ADDR_SELF_TEST = 8'h0A;
  localparam logic [7:0] ADDR_TS_MON = 8'h2F;
  localparam logic [7:0] ADDR_PCM_OUT = 8'h30;
  localparam logic [7:0] ADDR_LAW = 8'h3F;
  localparam logic [7:0] ADDR_CHAN_BASE = 8'h40;
  localparam logic [7:0] ADDR_CHAN_LAST = 8'h5F;
  localparam logic [7:0] ADDR_SER_MASK = 8'h6B;
  localparam logic [7:0] ADDR_FLEX_SER = 8'h6C;
  localparam logic [7:0] ADDR_FLEX_UCC = 8'h6D;
  localparam logic [7:0] ADDR_FLEX_MON = 8'h6F;

  // ****************************************************************
  // Key values and reset values
  // ****************************************************************
  localparam logic [7:0] UNLOCK_KEY = 8'h95;
  localparam logic [7:0] WDG_KEY_FIRST = 8'hAA;
  localparam logic [7:0] WDG_KEY_SECOND = 8'h99;
  localparam logic [7:0] WDG_KEY_THIRD = 8'h1D;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_HOST_IO = 8'h0F;
  localparam logic [3:0] RST_LOOP_CTRL = 4'h0;
  localparam logic [6:0] RST_IRQ_MASK = 7'h7F;
  localparam logic [6:0] RST_TS_MON = 7'h00;
  localparam logic [7:0] RST_PCM_OUT = 8'h03;
  localparam logic [3:0] RST_LAW = 4'h0;
  localparam logic [7:0] RST_CHAN = 8'h00;
  localparam logic [5:0] RST_SER_MASK = 6'h3F;
  localparam logic [5:0] RST_FLEX = 6'h00;
  localparam logic [7:0] RST_FLEX_MON = 8'hFE;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ST_RUN = 5;            // Self-test run bit
  localparam int LOOP_SR = 0;           // Send-to-receive loop
  localparam int LOOP_RS = 1;           // Receive-to-send loop
  localparam int TSM_MCH_MSB = 4;       // Monitored timeslot field top bit
  localparam int TSM_VALID = 5;         // Monitor enable
  localparam int IRQ_TSM = 0;           // Timeslot monitor flag in request/status
  localparam int LAW_SEL = 3;           // Per-channel law select
  localparam int LAW_DIS = 2;           // Global disable law
  localparam int LAW_NE = 1;            // Global near-end law
  localparam int LAW_FE = 0;            // Global far-end law
  localparam int CH_DIS_LAW = 7;
  localparam int CH_NE = 6;
  localparam int CH_FE = 5;
  localparam int CH_CONV_OFF = 4;
  localparam int CH_FREEZE = 3;
  localparam int CH_NLP = 2;
  localparam int CH_DISABLE = 1;
  localparam int CH_PRIO = 0;
  localparam int SM_CONV = 0;           // Serial mask: conversion-off pin
  localparam int SM_FREEZE = 1;
  localparam int SM_NLP = 2;
  localparam int SM_DISABLE = 3;
  localparam int SM_FLEX = 4;           // Flexible serial pin mask bit
  localparam int FX_EN = 0;             // Flex cfg: function enable
  localparam int FX_CLEAR = 5;          // Flex cfg: clear channel

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WDG_WINDOW_S = 2;
  localparam int unsigned WDG_WINDOW_CYC = WDG_WINDOW_S * CLK_HZ;

  // Watchdog key sequence states
  typedef enum logic [2:0] {
    WDG_IDLE = 3'b001,
    WDG_GOT1 = 3'b010,
    WDG_GOT2 = 3'b100
  } ecc_wdg_t;

endpackage : ecc_pkg

// ==== rtl/ecc_ctrl_regs.sv ====
// Module: host control/status register bank of the 32-channel echo canceller
// How it works
// - Protected registers accept writes only after the unlock key is written.
// - Writing any other value to the unlock register locks again.
// - Write-only registers read back as zero.
// - Scratch byte reads back, resets to zero, is protected, does nothing.
// - Host sets run bit; it stays set until test completes, then results valid.
// - Five read-only fail flags: central unit and four filter units.
// - Masked sources show in status but never set the request register.
// - Unmasking a still-active source other than the monitor flag raises a fresh request.
// - Enabled monitor captures chosen timeslot and flags it in request and status.
// - With both loops set only receive-to-send loop is active.
// - 32 channel registers; law bits used only with per-channel law select.
// - Channel freeze bit stops coefficient adaptation.
// - Channel NONLINEAR_PROCESSOR bypass bit routes around the nonlinear processor.
// - Channel disable bypasses path and resets coefficients and speech control.
// - Host priority makes only register bits apply for that channel.
// - Without priority, register bits are ORed with hardware sources.
// - Conversion-off may switch law when laws match and disable law differs.
// - Serial mask blocks serial pins, per host priority; resets to all ones.
// - Flexible serial pin function applies only while its mask bit is zero.
// - Flex CONTROL_COMM_HIGHWAY pattern with bits five and zero set enables clear channel.
// - Two nibbles select which state drives each monitor output; reset FEH.
// - Selector value zero drives the idle-channel indication.
module ecc_ctrl_regs import ecc_pkg::*; #(
  parameter int unsigned WDG_CYCLES = WDG_WINDOW_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  input wire logic [6:0] irq_src_i,
  input wire logic [6:0] irq_clr_i,
  output logic [6:0] interrupt_request_o,
  output logic [6:0] status_o,
  output logic self_test_start_o,
  input wire logic self_test_done_i,
  input wire logic [4:0] self_test_fail_i,
  output logic watchdog_serviced_o,
  input wire logic ts_proc_valid_i,
  input wire logic [4:0] ts_proc_index_i,
  input wire logic [7:0] ts_proc_data_i,
  output logic [7:0] monitor_read_o,
  output logic receive_to_send_loop_o,
  output logic send_to_receive_loop_o,
  output logic [1:0] pcm_bypass_o,
  output logic [7:0] host_io_pin_extension_o,
  output logic [7:0] pcm_output_global_cfg_o,
  input wire logic [31:0] ser_conv_i,
  input wire logic [31:0] ser_freeze_i,
  input wire logic [31:0] ser_nlp_i,
  input wire logic [31:0] ser_disable_i,
  input wire logic [31:0] flex_serial_pin_i,
  input wire logic [31:0] flexible_ucc_bit_i,
  input wire logic [31:0] ucc_disable_i,
  input wire logic [31:0] signalling_disable_i,
  input wire logic [31:0] idle_detect_i,
  output logic [31:0] law_conversion_off_o,
  output logic [31:0] freeze_o,
  output logic [31:0] nonlinear_processor_bypass_o,
  output logic [31:0] canceller_bypass_o,
  output logic [31:0] channel_reset_o,
  output logic [31:0] clear_channel_o,
  output logic [31:0] near_end_law_o,
  output logic [31:0] far_end_law_o,
  input wire logic [15:0] mon_state_i,
  output logic monitor_out_a_o,
  output logic monitor_out_b_o
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // Flexible source decode: {clear, disable, nlp, freeze, conv}
  function automatic logic [4:0] flex_decode(input logic [5:0] cfg, input logic pin);
    flex_decode = (cfg[FX_EN] && pin) ? cfg[5:1] : 5'h00;
  endfunction : flex_decode

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic unlocked_reg;
  logic [7:0] scratch_reg;
  logic [7:0] host_io_reg;
  logic [3:0] loop_ctrl_reg;
  logic [6:0] irq_mask_reg;
  logic st_run_reg;
  logic [4:0] st_fail_reg;
  logic [6:0] ts_mon_reg;
  logic [7:0] pcm_out_reg;
  logic [3:0] law_reg;
  logic [7:0] chan_reg [32];
  logic [5:0] ser_mask_reg;
  logic [5:0] flex_ser_reg;
  logic [5:0] flex_ucc_reg;
  logic [7:0] flex_mon_reg;
  logic [6:0] irq_src_prev_reg;
  logic [6:0] irq_mask_prev_reg;
  logic tsm_status_reg;
  ecc_wdg_t wdg_state_reg;
  logic [31:0] wdg_timer_reg;

  wire logic wr_en = ce_i && host_wr_i;
  wire logic prot_wr = wr_en && unlocked_reg;
  wire logic chan_hit = (host_addr_i >= ADDR_CHAN_BASE) && (host_addr_i <= ADDR_CHAN_LAST);
  wire logic [4:0] chan_idx = host_addr_i[4:0];
  wire logic tsm_hit = ce_i && ts_mon_reg[TSM_VALID] && ts_proc_valid_i
                       && (ts_proc_index_i == ts_mon_reg[TSM_MCH_MSB:0]);

  // ****************************************************************
  // Write protection
  // ****************************************************************

  // Unlock on key, lock on anything else
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      unlocked_reg <= 1'b0;
    end else if (wr_en && host_addr_i == ADDR_UNLOCK) begin
      unlocked_reg <= (host_wdata_i == UNLOCK_KEY);
    end
  end

  // ****************************************************************
  // Plain configuration registers
  // ****************************************************************

  // Unprotected registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      host_io_reg <= RST_HOST_IO;
      irq_mask_reg <= RST_IRQ_MASK;
      ts_mon_reg <= RST_TS_MON;
      flex_mon_reg <= RST_FLEX_MON;
    end else if (wr_en) begin
      if (host_addr_i == ADDR_HOST_IO) host_io_reg <= host_wdata_i;
      if (host_addr_i == ADDR_IRQ_MASK) irq_mask_reg <= host_wdata_i[6:0];
      if (host_addr_i == ADDR_TS_MON) ts_mon_reg <= host_wdata_i[6:0];
      if (host_addr_i == ADDR_FLEX_MON) flex_mon_reg <= host_wdata_i;
    end
  end

  // Protected registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      scratch_reg <= RST_SCRATCH;
      loop_ctrl_reg <= RST_LOOP_CTRL;
      pcm_out_reg <= RST_PCM_OUT;
      law_reg <= RST_LAW;
      ser_mask_reg <= RST_SER_MASK;
      flex_ser_reg <= RST_FLEX;
      flex_ucc_reg <= RST_FLEX;
    end else if (prot_wr) begin
      if (host_addr_i == ADDR_SCRATCH) scratch_reg <= host_wdata_i;
      if (host_addr_i == ADDR_LOOP_CTRL) loop_ctrl_reg <= host_wdata_i[3:0];
      if (host_addr_i == ADDR_PCM_OUT) pcm_out_reg <= host_wdata_i;
      if (host_addr_i == ADDR_LAW) law_reg <= host_wdata_i[3:0];
      if (host_addr_i == ADDR_SER_MASK) ser_mask_reg <= host_wdata_i[5:0];
      if (host_addr_i == ADDR_FLEX_SER) flex_ser_reg <= host_wdata_i[5:0];
      if (host_addr_i == ADDR_FLEX_UCC) flex_ucc_reg <= host_wdata_i[5:0];
    end
  end

  // Channel control registers, indexed by the low address bits
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 32; i++) begin
        chan_reg[i] <= RST_CHAN;
      end
    end else if (prot_wr && chan_hit) begin
      chan_reg[chan_idx] <= host_wdata_i;
    end
  end

  // ****************************************************************
  // RAM self-test
  // ****************************************************************

  // Run bit set by host, cleared by hardware
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_run_reg <= 1'b0;
      st_fail_reg <= 5'h00;
      self_test_start_o <= 1'b0;
    end else if (ce_i) begin
      self_test_start_o <= 1'b0;
      if (st_run_reg && self_test_done_i) begin
        st_run_reg <= 1'b0;
        st_fail_reg <= self_test_fail_i;
      end else if (!st_run_reg && prot_wr && host_addr_i == ADDR_SELF_TEST
                   && host_wdata_i[ST_RUN]) begin
        st_run_reg <= 1'b1;
        self_test_start_o <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Watchdog key sequence
  // ****************************************************************

  // Three keys in order; window runs from the first key
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wdg_state_reg <= WDG_IDLE;
      wdg_timer_reg <= 32'h0000_0000;
      watchdog_serviced_o <= 1'b0;
    end else if (ce_i) begin
      watchdog_serviced_o <= 1'b0;
      if (wdg_state_reg != WDG_IDLE) wdg_timer_reg <= wdg_timer_reg + 32'h0000_0001;
      if (wr_en && host_addr_i == ADDR_WDG_FIRST) begin
        wdg_timer_reg <= 32'h0000_0000;
        wdg_state_reg <= (host_wdata_i == WDG_KEY_FIRST) ? WDG_GOT1 : WDG_IDLE;
      end else if (wdg_state_reg != WDG_IDLE && wdg_timer_reg >= WDG_CYCLES - 1) begin
        wdg_state_reg <= WDG_IDLE;
      end else if (wr_en && (host_addr_i == ADDR_WDG_SECOND
                             || host_addr_i == ADDR_WDG_THIRD)) begin
        unique case (wdg_state_reg)
          WDG_GOT1: begin
            wdg_state_reg <= (host_addr_i == ADDR_WDG_SECOND
                              && host_wdata_i == WDG_KEY_SECOND) ? WDG_GOT2 : WDG_IDLE;
          end
          WDG_GOT2: begin
            wdg_state_reg <= WDG_IDLE;
            watchdog_serviced_o <= (host_addr_i == ADDR_WDG_THIRD
                                    && host_wdata_i == WDG_KEY_THIRD);
          end
          WDG_IDLE: begin
            wdg_state_reg <= WDG_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Interrupt request, status and timeslot monitor
  // ****************************************************************
  logic [6:0] src_now;
  logic [6:0] req_set;

  // Source levels, monitor flag in bit 0
  always_comb begin
    src_now = irq_src_i;
    src_now[IRQ_TSM] = tsm_status_reg;
    req_set = (src_now & ~irq_src_prev_reg & ~irq_mask_reg)
              | (src_now & irq_mask_prev_reg & ~irq_mask_reg);
    req_set[IRQ_TSM] = tsm_hit && !irq_mask_reg[IRQ_TSM];
  end

  // Monitor capture and its status flag
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      monitor_read_o <= 8'h00;
      tsm_status_reg <= 1'b0;
    end else if (ce_i) begin
      if (tsm_hit) begin
        monitor_read_o <= ts_proc_data_i;
        tsm_status_reg <= 1'b1;
      end else if (irq_clr_i[IRQ_TSM]) begin
        tsm_status_reg <= 1'b0;
      end
    end
  end

  // Sticky request bits; set beats clear
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      interrupt_request_o <= 7'h00;
      status_o <= 7'h00;
      irq_src_prev_reg <= 7'h00;
      irq_mask_prev_reg <= RST_IRQ_MASK;
    end else if (ce_i) begin
      interrupt_request_o <= (interrupt_request_o & ~irq_clr_i) | req_set;
      status_o <= src_now;
      irq_src_prev_reg <= src_now;
      irq_mask_prev_reg <= irq_mask_reg;
    end
  end

  // ****************************************************************
  // Host read port
  // ****************************************************************

  // Readable group answers, write-only group reads zero
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      host_rdata_o <= 8'h00;
    end else if (ce_i && host_rd_i) begin
      unique case (host_addr_i)
        ADDR_SCRATCH: host_rdata_o <= scratch_reg;
        ADDR_HOST_IO: host_rdata_o <= host_io_reg;
        ADDR_SELF_TEST: host_rdata_o <= {2'b00, st_run_reg, st_fail_reg};
        default: host_rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Global loop and output configuration
  // ****************************************************************

  // Loop priority and plain pass-out of settings
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      receive_to_send_loop_o <= 1'b0;
      send_to_receive_loop_o <= 1'b0;
      pcm_bypass_o <= 2'b00;
      host_io_pin_extension_o <= RST_HOST_IO;
      pcm_output_global_cfg_o <= RST_PCM_OUT;
    end else if (ce_i) begin
      receive_to_send_loop_o <= loop_ctrl_reg[LOOP_RS];
      send_to_receive_loop_o <= loop_ctrl_reg[LOOP_SR] && !loop_ctrl_reg[LOOP_RS];
      pcm_bypass_o <= loop_ctrl_reg[3:2];
      host_io_pin_extension_o <= host_io_reg;
      pcm_output_global_cfg_o <= pcm_out_reg;
    end
  end

  // ****************************************************************
  // Per-channel control merge
  // ****************************************************************
  wire logic [31:0] conv_next;
  wire logic [31:0] frz_next;
  wire logic [31:0] nlp_next;
  wire logic [31:0] dis_next;
  wire logic [31:0] clr_next;
  wire logic [31:0] ne_next;
  wire logic [31:0] fe_next;

  for (genvar c = 0; c < 32; c++) begin : g_chan
    wire logic [7:0] cr = chan_reg[c];
    wire logic prio = cr[CH_PRIO];
    // Flexible pin only counts while its mask bit is clear
    wire logic [4:0] fs = ser_mask_reg[SM_FLEX] ? 5'h00
                          : flex_decode(flex_ser_reg, flex_serial_pin_i[c]);
    wire logic [4:0] fu = flex_decode(flex_ucc_reg, flexible_ucc_bit_i[c]);
    wire logic hc = (ser_conv_i[c] && !ser_mask_reg[SM_CONV]) || fs[0] || fu[0];
    wire logic hf = (ser_freeze_i[c] && !ser_mask_reg[SM_FREEZE]) || fs[1] || fu[1];
    wire logic hn = (ser_nlp_i[c] && !ser_mask_reg[SM_NLP]) || fs[2] || fu[2];
    wire logic hd = (ser_disable_i[c] && !ser_mask_reg[SM_DISABLE]) || fs[3] || fu[3]
                    || ucc_disable_i[c] || signalling_disable_i[c] || idle_detect_i[c];
    // Clear channel needs both pattern bits
    wire logic cl = fs[4] || (fu[4] && flex_ucc_reg[FX_EN] && flex_ucc_reg[FX_CLEAR]);
    wire logic conv = cr[CH_CONV_OFF] || (!prio && hc);
    // Law source: channel bits only with per-channel selection
    wire logic sel = law_reg[LAW_SEL];
    wire logic dl = sel ? cr[CH_DIS_LAW] : law_reg[LAW_DIS];
    wire logic ne = sel ? cr[CH_NE] : law_reg[LAW_NE];
    wire logic fe = sel ? cr[CH_FE] : law_reg[LAW_FE];
    wire logic sw = conv && (ne == fe) && (dl != ne);
    assign conv_next[c] = conv;
    assign frz_next[c] = cr[CH_FREEZE] || (!prio && hf);
    assign nlp_next[c] = cr[CH_NLP] || (!prio && hn);
    assign dis_next[c] = cr[CH_DISABLE] || (!prio && hd);
    assign clr_next[c] = !prio && cl;
    assign ne_next[c] = sw ? dl : ne;
    assign fe_next[c] = sw ? dl : fe;
  end

  // Register the merged channel controls
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      law_conversion_off_o <= 32'h0000_0000;
      freeze_o <= 32'h0000_0000;
      nonlinear_processor_bypass_o <= 32'h0000_0000;
      canceller_bypass_o <= 32'h0000_0000;
      channel_reset_o <= 32'h0000_0000;
      clear_channel_o <= 32'h0000_0000;
      near_end_law_o <= 32'h0000_0000;
      far_end_law_o <= 32'h0000_0000;
    end else if (ce_i) begin
      law_conversion_off_o <= conv_next;
      freeze_o <= frz_next;
      nonlinear_processor_bypass_o <= nlp_next;
      canceller_bypass_o <= dis_next;
      channel_reset_o <= dis_next;
      clear_channel_o <= clr_next;
      near_end_law_o <= ne_next;
      far_end_law_o <= fe_next;
    end
  end

  // ****************************************************************
  // Flexible monitor outputs
  // ****************************************************************

  // Each nibble picks one internal state; index zero is idle detection
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      monitor_out_a_o <= 1'b0;
      monitor_out_b_o <= 1'b0;
    end else if (ce_i) begin
      monitor_out_a_o <= mon_state_i[flex_mon_reg[3:0]];
      monitor_out_b_o <= mon_state_i[flex_mon_reg[7:4]];
    end
  end

endmodule : ecc_ctrl_regs

// ==== sim/ecc_regs_asserts.sv ====
// Checker: port assertions of the control bank
module ecc_regs_chk (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic [6:0] irq_clr_i,
  input wire logic [6:0] interrupt_request_o,
  input wire logic self_test_start_o,
  input wire logic watchdog_serviced_o,
  input wire logic receive_to_send_loop_o,
  input wire logic send_to_receive_loop_o,
  input wire logic [7:0] host_io_pin_extension_o,
  input wire logic [31:0] canceller_bypass_o,
  input wire logic [31:0] channel_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // One key write
  sequence s_key(a, d);
    ce_i && host_wr_i && host_addr_i == a && host_wdata_i == d;
  endsequence
  // Three keys, host spacing
  sequence s_wdg;
    s_key(8'h02, 8'hAA) ##2 s_key(8'h03, 8'h99) ##2 s_key(8'h04, 8'h1D);
  endsequence
  AST_WDG_SERVICE: assert property (s_wdg |=> watchdog_serviced_o)
    else $error("no watchdog pulse");
  AST_WDG_CAUSE: assert property (watchdog_serviced_o |-> $past(host_wr_i && host_addr_i == 8'h04
    && host_wdata_i == 8'h1D) ##1 !watchdog_serviced_o)
    else $error("stray watchdog pulse");
  AST_WO_READ_ZERO: assert property (ce_i && host_rd_i && !(host_addr_i inside {8'h00, 8'h05,
    8'h0A}) |=> host_rdata_o == 8'h00)
    else $error("write-only read");
  AST_IO_READ: assert property (ce_i && host_rd_i && !host_wr_i && host_addr_i == 8'h05
    |=> host_rdata_o == host_io_pin_extension_o)
    else $error("pin extension read");
  AST_LOOP_PRIO: assert property (receive_to_send_loop_o |-> !send_to_receive_loop_o)
    else $error("both loops active");
  AST_START_CAUSE: assert property (self_test_start_o |-> $past(ce_i && host_wr_i
    && host_addr_i == 8'h0A && host_wdata_i[5]))
    else $error("stray self test start");
  AST_REQ_STICKY: assert property ((~interrupt_request_o & $past(interrupt_request_o)
    & ~$past(irq_clr_i)) == 7'h00)
    else $error("request dropped");
  AST_DISABLE_PAIR: assert property (canceller_bypass_o == channel_reset_o)
    else $error("bypass and reset differ");
endmodule : ecc_regs_chk

// ==== sim/ecc_bist_model.sv ====
// Partner: RAM self-test engine
module ecc_bist_model #(
  parameter int LAT = 12,
  parameter logic [4:0] FAIL = 5'h16
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  output logic done_o,
  output logic [4:0] fail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Count out each test run
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) cnt <= 0;
    else if (start_i) cnt <= LAT;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // Flags valid only with done
  assign done_o = (cnt == 1);
  assign fail_o = done_o ? FAIL : ~FAIL;
endmodule : ecc_bist_model

// ==== sim/tb_ecc_ctrl_regs.sv ====
// Testbench: directed scenarios for the register bank
module tb_ecc_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'h0;
  logic sys_rst_i, ce_i, host_wr_i, host_rd_i, self_test_done_i, ts_proc_valid_i;
  logic [7:0] host_addr_i, host_wdata_i, host_rdata_o, ts_proc_data_i, monitor_read_o;
  logic [7:0] host_io_pin_extension_o, pcm_output_global_cfg_o;
  logic [6:0] irq_src_i, irq_clr_i, interrupt_request_o, status_o;
  logic self_test_start_o, watchdog_serviced_o, monitor_out_a_o, monitor_out_b_o;
  logic receive_to_send_loop_o, send_to_receive_loop_o;
  logic [4:0] self_test_fail_i, ts_proc_index_i;
  logic [1:0] pcm_bypass_o;
  logic [15:0] mon_state_i;
  logic [31:0] ser_conv_i, ser_freeze_i, ser_nlp_i, ser_disable_i, flex_serial_pin_i;
  logic [31:0] flexible_ucc_bit_i, ucc_disable_i, signalling_disable_i, idle_detect_i;
  logic [31:0] law_conversion_off_o, freeze_o, nonlinear_processor_bypass_o, canceller_bypass_o;
  logic [31:0] channel_reset_o, clear_channel_o, near_end_law_o, far_end_law_o;
  int errors = 0;
  int n_checks = 0;
  // Clock
  always #5 ref_clk_i = ~ref_clk_i;
  ecc_ctrl_regs #(.WDG_CYCLES(50)) ecc_ctrl_regs_inst (.*);
  ecc_bist_model ecc_bist_model_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .start_i(self_test_start_o), .done_o(self_test_done_i), .fail_o(self_test_fail_i));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    host_addr_i <= a;
    host_wdata_i <= d;
    host_wr_i <= 1'h1;
    @(posedge ref_clk_i);
    host_wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge ref_clk_i);
    host_addr_i <= a;
    host_rd_i <= 1'h1;
    @(posedge ref_clk_i);
    host_rd_i <= 1'h0;
    @(negedge ref_clk_i);
    chk(what, {24'h0, e}, {24'h0, host_rdata_o});
  endtask : rd
  task automatic t_protect;
    rd(8'h00, 8'h00, "scratch reset");
    wr(8'h00, 8'h5A);
    rd(8'h00, 8'h00, "locked scratch");
    wr(8'h01, 8'h95);
    wr(8'h00, 8'h5A);
    rd(8'h00, 8'h5A, "unlocked scratch");
    wr(8'h01, 8'h00);
    wr(8'h00, 8'hC3);
    rd(8'h00, 8'h5A, "relocked scratch");
    rd(8'h07, 8'h00, "mask readback");
    $display("test protect done");
  endtask : t_protect
  task automatic t_bist;
    wr(8'h01, 8'h95);
    wr(8'h0A, 8'h20);
    rd(8'h0A, 8'h20, "run bit");
    for (int i = 0; i < 40 && self_test_done_i !== 1'h1; i++) @(posedge ref_clk_i);
    rd(8'h0A, 8'h16, "result");
    $display("test self test done");
  endtask : t_bist
  task automatic t_wdg;
    wr(8'h02, 8'hAA);
    wr(8'h03, 8'h99);
    wr(8'h04, 8'h1D);
    @(negedge ref_clk_i);
    chk("serviced", 32'h1, {31'h0, watchdog_serviced_o});
    wr(8'h02, 8'hAA);
    wr(8'h03, 8'h98);
    wr(8'h04, 8'h1D);
    @(negedge ref_clk_i);
    chk("bad key", 32'h0, {31'h0, watchdog_serviced_o});
    $display("test watchdog done");
  endtask : t_wdg
  task automatic t_irq;
    @(posedge ref_clk_i);
    irq_src_i <= 7'h02;
    repeat (3) @(negedge ref_clk_i);
    chk("status", 32'h2, {25'h0, status_o});
    chk("masked request", 32'h0, {25'h0, interrupt_request_o});
    wr(8'h07, 8'h00);
    repeat (2) @(negedge ref_clk_i);
    chk("unmasked request", 32'h2, {25'h0, interrupt_request_o});
    wr(8'h2F, 8'h27);
    @(posedge ref_clk_i);
    ts_proc_valid_i <= 1'h1;
    ts_proc_index_i <= 5'h07;
    ts_proc_data_i <= 8'hA5;
    @(posedge ref_clk_i);
    ts_proc_valid_i <= 1'h0;
    repeat (2) @(negedge ref_clk_i);
    chk("monitor value", 32'hA5, {24'h0, monitor_read_o});
    chk("monitor request", 32'h3, {25'h0, interrupt_request_o});
    $display("test interrupts done");
  endtask : t_irq
  task automatic t_chan;
    wr(8'h06, 8'h03);
    repeat (2) @(negedge ref_clk_i);
    chk("loops", 32'h2, {30'h0, receive_to_send_loop_o, send_to_receive_loop_o});
    @(posedge ref_clk_i);
    {ser_conv_i, ser_freeze_i, ser_nlp_i, ser_disable_i, flex_serial_pin_i} <= '1;
    {flexible_ucc_bit_i, ucc_disable_i, signalling_disable_i, idle_detect_i} <= '1;
    repeat (2) @(negedge ref_clk_i);
    chk("masked freeze", 32'h0, {31'h0, freeze_o[6]});
    wr(8'h6B, 8'h00);
    repeat (2) @(negedge ref_clk_i);
    chk("ored freeze", 32'h1, {31'h0, freeze_o[5]});
    wr(8'h45, 8'h01);
    repeat (2) @(negedge ref_clk_i);
    chk("priority freeze", 32'h0, {31'h0, freeze_o[5]});
    chk("priority bypass", 32'h0, {31'h0, canceller_bypass_o[5]});
    wr(8'h6F, 8'h00);
    @(posedge ref_clk_i);
    mon_state_i <= 16'h0001;
    repeat (2) @(negedge ref_clk_i);
    chk("monitor pin", 32'h1, {31'h0, monitor_out_a_o});
    $display("test channels done");
  endtask : t_chan
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    {sys_rst_i, ce_i} = 2'h3;
    {host_wr_i, host_rd_i, ts_proc_valid_i, host_addr_i, host_wdata_i, ts_proc_data_i} = '0;
    {irq_src_i, irq_clr_i, ts_proc_index_i, mon_state_i} = '0;
    {ser_conv_i, ser_freeze_i, ser_nlp_i, ser_disable_i, flex_serial_pin_i} = '0;
    {flexible_ucc_bit_i, ucc_disable_i, signalling_disable_i, idle_detect_i} = '0;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'h0;
    t_protect();
    t_bist();
    t_wdg();
    t_irq();
    t_chan();
    report_and_stop();
  end
  // Hang guard
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    errors++;
    report_and_stop();
  end
endmodule : tb_ecc_ctrl_regs
bind ecc_ctrl_regs ecc_regs_chk ecc_regs_chk_inst (.*);
